//--- hw/mmcr_top.v
// measurement and accumulation mode registers with the logic they steer
// How it works
// - period source code picks phase A, B, C
// - period code 11 acts as phase A
// - bits 2..4 enable peak capture per phase
// - any peak select combination works concurrently
// - zero crossings counted from every selected phase
// - mode bits 7..5 reserved, no effect
// - active code 00 accumulates signed
// - active codes 01, 10 act as signed
// - active code 11 accumulates absolute value
// - reactive code 00 accumulates signed
// - reactive code 10 follows active power sign
// - reactive codes 01, 11 act as signed
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "mmcr_consts.vh"

module mmcr_top #(
  parameter PW = 24,
  parameter AW = 32,
  parameter SW = 24,
  parameter PERW = 16
) (
  input wire mclk,
  input wire rstn,
  input wire [15:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata_r,
  input wire [2:0] zxIn,
  input wire sampValid,
  input wire [3*SW-1:0] vSamp,
  input wire [3*SW-1:0] iSamp,
  input wire powValid,
  input wire accClear,
  input wire [3*PW-1:0] actTot,
  input wire [3*PW-1:0] actFund,
  input wire [3*PW-1:0] reaTot,
  input wire [3*PW-1:0] reaFund,
  output wire [3*AW-1:0] actAccTot,
  output wire [3*AW-1:0] actAccFund,
  output wire [3*AW-1:0] reaAccTot,
  output wire [3*AW-1:0] reaAccFund,
  output reg [PERW-1:0] linePeriod_r,
  output reg periodValid_r,
  output reg [SW-1:0] vPeak_r,
  output reg [SW-1:0] iPeak_r,
  output reg [2:0] vPeakPhase_r,
  output reg [2:0] iPeakPhase_r,
  output reg peakDone_r
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  function [1:0] lineIdx;
    input [1:0] code;
    begin
      case (code)
        `MMCR_PER_PHB: lineIdx = 2'd1;
        `MMCR_PER_PHC: lineIdx = 2'd2;
        default: lineIdx = 2'd0;
      endcase
    end
  endfunction

  function [SW-1:0] absVal;
    input [SW-1:0] v;
    begin
      absVal = v[SW-1] ? (~v + {{(SW-1){1'b0}}, 1'b1}) : v;
    end
  endfunction

  function [1:0] ones3;
    input [2:0] b;
    begin
      ones3 = {1'b0, b[0]} + {1'b0, b[1]} + {1'b0, b[2]};
    end
  endfunction

  // ----------------------------------------
  // mode registers
  // ----------------------------------------
  reg [1:0] line_period_phase_select_r;
  reg [2:0] peak_phase_select_r;
  reg [1:0] active_accum_mode_r;
  reg [1:0] reactive_accum_mode_r;
  reg [7:0] peak_cycle_count_r;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      line_period_phase_select_r <= `MMCR_PSRC_RST;
      peak_phase_select_r <= `MMCR_PKSEL_RST;
      active_accum_mode_r <= `MMCR_WACC_RST;
      reactive_accum_mode_r <= `MMCR_VACC_RST;
      peak_cycle_count_r <= `MMCR_PKCNT_RST;
    end else if (regWr) begin
      case (regAddr)
        `MMCR_ADDR_MEAS: begin
          line_period_phase_select_r <= regWdata[`MMCR_PSRC_MSB:`MMCR_PSRC_LSB];
          peak_phase_select_r <= regWdata[`MMCR_PKSEL_MSB:`MMCR_PKSEL_LSB];
          // upper bits dropped, they steer nothing
        end
        `MMCR_ADDR_ACCUM: begin
          active_accum_mode_r <= regWdata[`MMCR_WACC_MSB:`MMCR_WACC_LSB];
          reactive_accum_mode_r <= regWdata[`MMCR_VACC_MSB:`MMCR_VACC_LSB];
        end
        `MMCR_ADDR_PKCNT: begin
          peak_cycle_count_r <= regWdata;
        end
        default: begin
          peak_cycle_count_r <= peak_cycle_count_r;
        end
      endcase
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  reg [7:0] rdMux;

  always @* begin
    case (regAddr)
      `MMCR_ADDR_MEAS: rdMux = {3'h0, peak_phase_select_r, line_period_phase_select_r};
      `MMCR_ADDR_ACCUM: rdMux = {4'h0, reactive_accum_mode_r, active_accum_mode_r};
      `MMCR_ADDR_PKCNT: rdMux = peak_cycle_count_r;
      `MMCR_ADDR_PEAKSTAT: rdMux = {2'h0, iPeakPhase_r, vPeakPhase_r};
      `MMCR_ADDR_PERLO: rdMux = linePeriod_r[7:0];
      `MMCR_ADDR_PERHI: rdMux = linePeriod_r[15:8];
      default: rdMux = 8'h00;
    endcase
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      regRdata_r <= 8'h00;
    end else if (regRd) begin
      regRdata_r <= rdMux;
    end else begin
      regRdata_r <= 8'h00;
    end
  end

  // ----------------------------------------
  // line period measurement
  // ----------------------------------------
  reg [PERW-1:0] perCnt_r;
  reg perArmed_r;
  wire perZx;

  assign perZx = zxIn[lineIdx(line_period_phase_select_r)];

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      perCnt_r <= {PERW{1'b0}};
      perArmed_r <= 1'b0;
      linePeriod_r <= {PERW{1'b0}};
      periodValid_r <= 1'b0;
    end else begin
      periodValid_r <= 1'b0;
      if (perZx) begin
        perCnt_r <= {{(PERW-1){1'b0}}, 1'b1};
        perArmed_r <= 1'b1;
        if (perArmed_r) begin
          linePeriod_r <= perCnt_r;
          periodValid_r <= 1'b1;
        end
      end else if (perCnt_r != {PERW{1'b1}}) begin
        perCnt_r <= perCnt_r + {{(PERW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------
  // peak detection over selected phases
  // ----------------------------------------
  reg [SW-1:0] vRun_r;
  reg [SW-1:0] iRun_r;
  reg [2:0] vRunPh_r;
  reg [2:0] iRunPh_r;
  reg [8:0] pkZxCnt_r;
  reg [SW-1:0] vRunNxt;
  reg [SW-1:0] iRunNxt;
  reg [2:0] vRunPhNxt;
  reg [2:0] iRunPhNxt;
  reg [SW-1:0] vAbs;
  reg [SW-1:0] iAbs;
  integer k;
  wire [2:0] pkZx;
  wire [8:0] pkZxSum;
  wire pkEnd;

  assign pkZx = zxIn & peak_phase_select_r;
  assign pkZxSum = pkZxCnt_r + {7'h00, ones3(pkZx)};
  assign pkEnd = (peak_cycle_count_r != 8'h00) && (pkZx != 3'h0) && (pkZxSum >= {1'b0, peak_cycle_count_r});

  always @* begin
    vRunNxt = vRun_r;
    iRunNxt = iRun_r;
    vRunPhNxt = vRunPh_r;
    iRunPhNxt = iRunPh_r;
    vAbs = {SW{1'b0}};
    iAbs = {SW{1'b0}};
    for (k = 0; k < 3; k = k + 1) begin
      if (sampValid && peak_phase_select_r[k]) begin
        vAbs = absVal(vSamp[k*SW +: SW]);
        iAbs = absVal(iSamp[k*SW +: SW]);
        if (vAbs > vRunNxt) begin
          vRunNxt = vAbs;
          vRunPhNxt = 3'h0;
          vRunPhNxt[k] = 1'b1;
        end else if (vAbs == vRunNxt && vAbs != {SW{1'b0}}) begin
          vRunPhNxt[k] = 1'b1;
        end
        if (iAbs > iRunNxt) begin
          iRunNxt = iAbs;
          iRunPhNxt = 3'h0;
          iRunPhNxt[k] = 1'b1;
        end else if (iAbs == iRunNxt && iAbs != {SW{1'b0}}) begin
          iRunPhNxt[k] = 1'b1;
        end
      end
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      vRun_r <= {SW{1'b0}};
      iRun_r <= {SW{1'b0}};
      vRunPh_r <= 3'h0;
      iRunPh_r <= 3'h0;
      pkZxCnt_r <= 9'h000;
      vPeak_r <= {SW{1'b0}};
      iPeak_r <= {SW{1'b0}};
      vPeakPhase_r <= 3'h0;
      iPeakPhase_r <= 3'h0;
      peakDone_r <= 1'b0;
    end else begin
      peakDone_r <= 1'b0;
      if (pkEnd) begin
        vPeak_r <= vRunNxt;
        iPeak_r <= iRunNxt;
        vPeakPhase_r <= vRunPhNxt;
        iPeakPhase_r <= iRunPhNxt;
        peakDone_r <= 1'b1;
        vRun_r <= {SW{1'b0}};
        iRun_r <= {SW{1'b0}};
        vRunPh_r <= 3'h0;
        iRunPh_r <= 3'h0;
        pkZxCnt_r <= 9'h000;
      end else begin
        vRun_r <= vRunNxt;
        iRun_r <= iRunNxt;
        vRunPh_r <= vRunPhNxt;
        iRunPh_r <= iRunPhNxt;
        pkZxCnt_r <= pkZxSum;
      end
    end
  end

  // ----------------------------------------
  // accumulation mode decode
  // ----------------------------------------
  wire actAbs;
  wire reaCond;

  assign actAbs = (active_accum_mode_r == `MMCR_WACC_ABS);
  assign reaCond = (reactive_accum_mode_r == `MMCR_VACC_COND);

  // ----------------------------------------
  // accumulators, four kinds per phase
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gPhase
      mmcr_accum #(.PW(PW), .AW(AW)) uActTot (
        .mclk(mclk),
        .rstn(rstn),
        .clear(accClear),
        .strobe(powValid),
        .power(actTot[g*PW +: PW]),
        .refNeg(1'b0),
        .absMode(actAbs),
        .condMode(1'b0),
        .acc_r(actAccTot[g*AW +: AW])
      );
      mmcr_accum #(.PW(PW), .AW(AW)) uActFund (
        .mclk(mclk),
        .rstn(rstn),
        .clear(accClear),
        .strobe(powValid),
        .power(actFund[g*PW +: PW]),
        .refNeg(1'b0),
        .absMode(actAbs),
        .condMode(1'b0),
        .acc_r(actAccFund[g*AW +: AW])
      );
      mmcr_accum #(.PW(PW), .AW(AW)) uReaTot (
        .mclk(mclk),
        .rstn(rstn),
        .clear(accClear),
        .strobe(powValid),
        .power(reaTot[g*PW +: PW]),
        .refNeg(actTot[g*PW+PW-1]),
        .absMode(1'b0),
        .condMode(reaCond),
        .acc_r(reaAccTot[g*AW +: AW])
      );
      mmcr_accum #(.PW(PW), .AW(AW)) uReaFund (
        .mclk(mclk),
        .rstn(rstn),
        .clear(accClear),
        .strobe(powValid),
        .power(reaFund[g*PW +: PW]),
        .refNeg(actFund[g*PW+PW-1]),
        .absMode(1'b0),
        .condMode(reaCond),
        .acc_r(reaAccFund[g*AW +: AW])
      );
    end
  endgenerate

endmodule // mmcr_top

`default_nettype wire

//--- hw/mmcr_consts.vh
// constants for the metering mode configuration registers
`ifndef MMCR_CONSTS_VH
`define MMCR_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MMCR_ADDR_MEAS 16'he700
`define MMCR_ADDR_ACCUM 16'he701
`define MMCR_ADDR_PKCNT 16'he710
`define MMCR_ADDR_PEAKSTAT 16'he711
`define MMCR_ADDR_PERLO 16'he712
`define MMCR_ADDR_PERHI 16'he713

// ----------------------------------------
// field positions
// ----------------------------------------
`define MMCR_PSRC_LSB 0
`define MMCR_PSRC_MSB 1
`define MMCR_PKSEL_LSB 2
`define MMCR_PKSEL_MSB 4
`define MMCR_WACC_LSB 0
`define MMCR_WACC_MSB 1
`define MMCR_VACC_LSB 2
`define MMCR_VACC_MSB 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define MMCR_PSRC_RST 2'h0
`define MMCR_PKSEL_RST 3'h7
`define MMCR_WACC_RST 2'h0
`define MMCR_VACC_RST 2'h0
`define MMCR_PKCNT_RST 8'h00

// ----------------------------------------
// mode codes
// ----------------------------------------
`define MMCR_PER_PHA 2'h0
`define MMCR_PER_PHB 2'h1
`define MMCR_PER_PHC 2'h2
`define MMCR_WACC_ABS 2'h3
`define MMCR_VACC_COND 2'h2

`endif

//--- hw/mmcr_accum.v
// one energy accumulator with signed, absolute and sign-conditioned modes
`timescale 1ns/1ps
`default_nettype none

module mmcr_accum #(
  parameter PW = 24,
  parameter AW = 32
) (
  input wire mclk,
  input wire rstn,
  input wire clear,
  input wire strobe,
  input wire [PW-1:0] power,
  input wire refNeg,
  input wire absMode,
  input wire condMode,
  output reg [AW-1:0] acc_r
);

  wire [AW-1:0] ext;
  reg [AW-1:0] addend;

  assign ext = {{(AW-PW){power[PW-1]}}, power};

  // ----------------------------------------
  // addend selection
  // ----------------------------------------
  always @* begin
    addend = ext;
    if (absMode && power[PW-1]) begin
      addend = -ext;
    end else if (condMode && refNeg) begin
      addend = -ext;
    end
  end

  // ----------------------------------------
  // accumulator; mode changes never touch the sum
  // ----------------------------------------
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= {AW{1'b0}};
    end else if (clear) begin
      acc_r <= {AW{1'b0}};
    end else if (strobe) begin
      acc_r <= acc_r + addend;
    end
  end

endmodule // mmcr_accum

`default_nettype wire

//--- tb/mmcr_checker.sv
// assertion checker for the metering mode registers
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// mode checks
// ----------------------------------------
module mmcr_checker #(
  parameter PW = 24,
  parameter AW = 32
) (
  input wire mclk,
  input wire rstn,
  input wire [15:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  input wire [7:0] regRdata_r,
  input wire [2:0] zxIn,
  input wire powValid,
  input wire accClear,
  input wire [3*PW-1:0] actTot,
  input wire [3*PW-1:0] reaTot,
  input wire [3*AW-1:0] actAccTot,
  input wire [3*AW-1:0] reaAccTot,
  input wire periodValid_r
);
  reg [7:0] mm_r;
  reg [3:0] am_r;
  wire [2:0] perMask = (mm_r[1:0] == 2'h1) ? 3'h2 : (mm_r[1:0] == 2'h2) ? 3'h4 : 3'h1;
  wire [AW-1:0] aA = {{(AW-PW){actTot[PW-1]}}, actTot[PW-1:0]};
  wire [AW-1:0] rA = {{(AW-PW){reaTot[PW-1]}}, reaTot[PW-1:0]};
  wire [AW-1:0] wA = actAccTot[AW-1:0];
  wire [AW-1:0] vA = reaAccTot[AW-1:0];
  wire [AW-1:0] aAbs = aA[AW-1] ? -aA : aA;
  wire [AW-1:0] rCond = actTot[PW-1] ? -rA : rA;
  wire take = powValid && !accClear;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mm_r <= 8'h1c;
      am_r <= 4'h0;
    end else if (regWr && regAddr == 16'he700) begin
      mm_r <= {3'h0, regWdata[4:0]};
    end else if (regWr && regAddr == 16'he701) begin
      am_r <= regWdata[3:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  AST_PER_SRC: assert property (periodValid_r |-> |($past(zxIn) & $past(perMask)))
    else $error("period update without selected crossing");
  AST_PER_RSV: assert property (mm_r[1:0] == 2'h3 && zxIn == 3'h6 |=> !periodValid_r)
    else $error("reserved period code used wrong phase");
  AST_RSV_RD: assert property (regRd && regAddr == 16'he700 |=> regRdata_r == $past(mm_r))
    else $error("mode register read back wrong");
  AST_WSIGN: assert property (take && am_r[1:0] != 2'h3 |=> wA == $past(wA) + $past(aA))
    else $error("signed active sum wrong");
  AST_WABS: assert property (take && am_r[1:0] == 2'h3 |=> wA == $past(wA) + $past(aAbs))
    else $error("absolute active sum wrong");
  AST_VSIGN: assert property (take && am_r[3:2] != 2'h2 |=> vA == $past(vA) + $past(rA))
    else $error("signed reactive sum wrong");
  AST_VCOND: assert property (take && am_r[3:2] == 2'h2 |=> vA == $past(vA) + $past(rCond))
    else $error("sign conditioned reactive sum wrong");
  AST_HOLD: assert property (!powValid && !accClear |=> $stable(actAccTot) && $stable(reaAccTot))
    else $error("sums moved without power strobe");
  COV_PER: cover property (periodValid_r);
  COV_ABS: cover property (take && am_r[1:0] == 2'h3);
  COV_COND: cover property (take && am_r[3:2] == 2'h2);
endmodule // mmcr_checker
bind mmcr_top mmcr_checker #(.PW(PW), .AW(AW)) i_mmcr_checker (.mclk, .rstn, .regAddr, .regWdata, .regWr,
  .regRd, .regRdata_r, .zxIn, .powValid, .accClear, .actTot, .reaTot, .actAccTot, .reaAccTot, .periodValid_r);
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench for the metering mode registers
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// bench
// ----------------------------------------
module testbench;
  localparam PW = 24;
  localparam AW = 32;
  reg mclk = 1'b0;
  reg rstn = 1'b0;
  reg [15:0] regAddr = 16'h0;
  reg [7:0] regWdata = 8'h0;
  reg regWr = 1'b0, regRd = 1'b0, sampValid = 1'b0, powValid = 1'b0, accClear = 1'b0;
  reg [2:0] zxIn = 3'h0;
  reg [71:0] vSamp = 72'h0, iSamp = 72'h0;
  reg [3*PW-1:0] pw [0:3];
  reg [95:0] rv [0:3];
  reg [AW-1:0] ex [0:3][0:2];
  wire [3*AW-1:0] acc [0:3];
  wire [7:0] regRdata_r;
  wire [15:0] linePeriod_r;
  wire [23:0] vPeak_r, iPeak_r;
  wire [2:0] vPeakPhase_r, iPeakPhase_r;
  wire periodValid_r, peakDone_r;
  reg [23:0] pkV = 24'h0, pkI = 24'h0;
  reg [5:0] pkP = 6'h0;
  reg [3:0] am = 4'h0;
  reg [7:0] d;
  integer n_fail = 0, tests_run = 0, i, j, k, p, n;
  mmcr_top #(.PW(PW), .AW(AW)) i_mmcr_top (.mclk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata_r,
    .zxIn, .sampValid, .vSamp, .iSamp, .powValid, .accClear, .actTot(pw[0]), .actFund(pw[1]), .reaTot(pw[2]),
    .reaFund(pw[3]), .actAccTot(acc[0]), .actAccFund(acc[1]), .reaAccTot(acc[2]), .reaAccFund(acc[3]),
    .linePeriod_r, .periodValid_r, .vPeak_r, .iPeak_r, .vPeakPhase_r, .iPeakPhase_r, .peakDone_r);
  always #20 mclk = ~mclk;
  always @(posedge mclk) if (peakDone_r === 1'b1) begin
    pkV <= vPeak_r;
    pkI <= iPeak_r;
    pkP <= {iPeakPhase_r, vPeakPhase_r};
  end
  task bus(input w, input [15:0] a, input [7:0] v);
    begin
      regAddr <= a;
      regWdata <= v;
      regWr <= w;
      regRd <= !w;
      @(posedge mclk);
      regWr <= 1'b0;
      regRd <= 1'b0;
      @(negedge mclk) d = regRdata_r;
      @(posedge mclk);
    end
  endtask
  task cmp(input string nm, input [AW-1:0] e, input [AW-1:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  function [AW-1:0] addv(input integer c, input [PW-1:0] v, input [PW-1:0] a, input [3:0] m);
    reg [AW-1:0] s;
    begin
      s = {{(AW-PW){v[PW-1]}}, v};
      if (c < 2 && m[1:0] == 2'h3 && v[PW-1]) s = -s;
      if (c >= 2 && m[3:2] == 2'h2 && a[PW-1]) s = -s;
      addv = s;
    end
  endfunction
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    for (j = 0; j < 4; j = j + 1) begin
      pw[j] = 72'h0;
      for (p = 0; p < 3; p = p + 1) ex[j][p] = 32'h0;
    end
    n = $urandom(32'hc30765fa);
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    bus(1'b0, 16'he700, 8'h0);
    cmp("mode reset", 8'h1c, d);
    bus(1'b0, 16'he701, 8'h0);
    cmp("accum reset", 8'h00, d);
    bus(1'b0, 16'h1234, 8'h0);
    cmp("unmapped", 8'h00, d);
    bus(1'b1, 16'he700, 8'hff);
    bus(1'b0, 16'he700, 8'h0);
    cmp("mode reserved", 8'h1f, d);
    bus(1'b1, 16'he701, 8'hff);
    bus(1'b0, 16'he701, 8'h0);
    cmp("accum reserved", 8'h0f, d);
    $display("test registers done");
    for (k = 0; k < 4; k = k + 1) begin
      bus(1'b1, 16'he700, {6'h07, k[1:0]});
      p = (k == 1) ? 1 : (k == 2) ? 2 : 0;
      n = 3 + $urandom_range(30);
      zxIn <= 3'h1 << p;
      @(posedge mclk);
      zxIn <= ~(3'h1 << p);
      @(posedge mclk);
      zxIn <= 3'h0;
      repeat (n - 2) @(posedge mclk);
      zxIn <= 3'h1 << p;
      @(posedge mclk);
      zxIn <= 3'h0;
      @(negedge mclk);
      cmp("period valid", 1'b1, periodValid_r);
      repeat (2) @(posedge mclk);
      cmp("period", n, linePeriod_r);
      bus(1'b0, 16'he712, 8'h0);
      cmp("period low", n[7:0], d);
      bus(1'b0, 16'he713, 8'h0);
      cmp("period high", n[15:8], d);
    end
    $display("test period done");
    am = 4'hf;
    for (i = 0; i < 300; i = i + 1) begin
      k = $urandom;
      powValid <= k[0];
      accClear <= (k[4:1] == 4'h0);
      regWr <= k[8] & k[9];
      regAddr <= 16'he701;
      regWdata <= k[31:24];
      for (j = 0; j < 4; j = j + 1) begin
        rv[j] = {$urandom, $urandom, $urandom};
        pw[j] <= rv[j][71:0];
      end
      for (j = 0; j < 4; j = j + 1) for (p = 0; p < 3; p = p + 1) begin
        if (k[4:1] == 4'h0) ex[j][p] = 32'h0;
        else if (k[0]) ex[j][p] = ex[j][p] + addv(j, rv[j][p*PW+:PW], rv[j&1][p*PW+:PW], am);
      end
      if (k[8] & k[9]) am = k[27:24];
      @(posedge mclk);
    end
    powValid <= 1'b0;
    accClear <= 1'b0;
    regWr <= 1'b0;
    @(posedge mclk);
    for (j = 0; j < 4; j = j + 1) for (p = 0; p < 3; p = p + 1)
      cmp("accumulator", ex[j][p], acc[j][p*AW+:AW]);
    $display("test accumulate done");
    bus(1'b1, 16'he710, 8'h01);
    bus(1'b1, 16'he700, 8'h04);
    zxIn <= 3'h1;
    @(posedge mclk);
    zxIn <= 3'h0;
    @(posedge mclk);
    bus(1'b1, 16'he710, 8'h02);
    bus(1'b0, 16'he710, 8'h0);
    cmp("peak cycle count", 8'h02, d);
    vSamp <= {24'h000064, 24'h000064, 24'hfffff9};
    iSamp <= {24'h000000, 24'hffffc4, 24'h000005};
    for (k = 0; k < 2; k = k + 1) begin
      sampValid <= 1'b1;
      @(posedge mclk);
      sampValid <= 1'b0;
      for (i = 0; i < 2 - k; i = i + 1) begin
        zxIn <= (k == 0) ? 3'h1 : 3'h3;
        @(posedge mclk);
        zxIn <= 3'h0;
        repeat (3) @(posedge mclk);
      end
      cmp("voltage peak", (k == 0) ? 24'h000007 : 24'h000064, pkV);
      cmp("current peak", (k == 0) ? 24'h000005 : 24'h00003c, pkI);
      cmp("peak phases", (k == 0) ? 6'h09 : 6'h16, pkP);
      bus(1'b0, 16'he711, 8'h0);
      cmp("peak status", (k == 0) ? 6'h09 : 6'h16, d);
      bus(1'b1, 16'he700, 8'h1c);
    end
    $display("test peak done");
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
